// ### rtl/tmc_regs.svh
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define TMC_OFF_CNT_LOW   8'h00
`define TMC_OFF_CNT_HIGH  8'h04
`define TMC_OFF_CTRL      8'h08
`define TMC_OFF_IRQ_FLAG  8'h0C
`define TMC_OFF_IRQ_EN    8'h10
`define TMC_OFF_IRQ_PRIO  8'h14

// ----------------------------------------------------------------
// counter_control fields
// ----------------------------------------------------------------
`define TMC_CTRL_WIDE     7
`define TMC_CTRL_PS_HI    5
`define TMC_CTRL_PS_LO    4
`define TMC_CTRL_CMP_SRC  3
`define TMC_CTRL_NOSYNC   2
`define TMC_CTRL_CLK_SRC  1
`define TMC_CTRL_ON       0
`define TMC_CTRL_MASK     8'hBF

// ----------------------------------------------------------------
// interrupt register bit, reset values, timing
// ----------------------------------------------------------------
`define TMC_IRQ_BIT       1
`define TMC_CTRL_RST      8'h00
`define TMC_BYTE_RST      8'h00
`define TMC_INSTR_DIV     2'h3

`endif

// ### rtl/tmc_pkg.sv
package tmc_pkg;

    // clock modes of the counter, one-hot
    typedef enum logic [2:0] {
        TMC_MODE_TIMER = 3'b001,
        TMC_MODE_SYNC  = 3'b010,
        TMC_MODE_ASYNC = 3'b100
    } tmc_mode_e;

    typedef logic [7:0] tmc_byte_t;

endpackage

// ### rtl/tmc_ext_edge.sv
`timescale 1ns/1ns
`default_nettype none

module tmc_ext_edge
    import tmc_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    // pin side
    input  wire logic clk_pin,
    // count side
    output logic      rise_pulse
);

    // ----------------------------------------------------------------
    // synchroniser and armed rising edge
    // ----------------------------------------------------------------
    logic meta_ff;
    logic sync_ff;
    logic last_ff;
    logic armed_ff;
    logic nxt_armed;

    // a rising edge counts only once a falling edge has been seen
    always_comb
    begin
        nxt_armed = armed_ff | (last_ff & ~sync_ff);
        rise_pulse = armed_ff & sync_ff & ~last_ff;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_ff  <= 1'b0;
            sync_ff  <= 1'b0;
            last_ff  <= 1'b0;
            armed_ff <= 1'b0;
        end
        else
        begin
            meta_ff  <= clk_pin;
            sync_ff  <= meta_ff;
            last_ff  <= sync_ff;
            armed_ff <= nxt_armed;
        end
    end

endmodule
`default_nettype wire

// ### rtl/tmc_prescaler.sv
`timescale 1ns/1ns
`default_nettype none

module tmc_prescaler
    import tmc_pkg::*;
#(
    parameter int SEL_W = 2
)
(
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    // control
    input  wire logic             clear,
    input  wire logic [SEL_W-1:0] ratio_sel,
    // ticks
    input  wire logic             tick_in,
    output logic                  tick_out
);

    localparam int CNT_W = (1 << SEL_W) - 1;

    if (SEL_W < 1 || SEL_W > 4)
    begin : g_bad_sel
        $error("tmc_prescaler: SEL_W out of range");
    end

    // ----------------------------------------------------------------
    // divide by 2**ratio_sel
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] div_ff;
    logic [CNT_W-1:0] nxt_div;
    logic [CNT_W-1:0] limit;

    always_comb
    begin
        limit    = CNT_W'((1 << ratio_sel) - 1);
        tick_out = tick_in & (div_ff >= limit);
        nxt_div  = div_ff;
        if (clear)
            nxt_div = '0;
        else if (tick_out)
            nxt_div = '0;
        else if (tick_in)
            nxt_div = div_ff + CNT_W'(1);
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            div_ff <= '0;
        else
            div_ff <= nxt_div;
    end

endmodule
`default_nettype wire

// ### rtl/tmc_top.sv
// Notes on behaviour
// [R1] timer, synchronous counter and asynchronous counter, picked by control bits
// [R2] clock source select clear: count once per instruction cycle, clock over four
// [R3] clock source select set: count rising edges of external clock or oscillator
// [R4] oscillator enabled: oscillator pins read zero, their direction bits ignored
// [R5] wide mode: high address hits buffer; low read copies live high byte
// [R6] wide mode: high write loads buffer; low write moves buffer to high
// [R7] wide mode: live high byte never directly read or written
// [R8] low byte write clears prescaler; high byte write leaves it alone
// [R9] software sets oscillator enable and clock source select to use oscillator
// [R10] sixteen bit up-counter wraps from all ones to zero
// [R11] overflow sets sticky flag, held until software clears it
// [R12] overflow request forwarded only while its enable bit is set
// [R13] special event trigger resets counter when compare uses this counter
// [R14] trigger reset relies on timer or synchronous mode, not asynchronous
// [R15] software write in same cycle as trigger wins over the reset
// [R16] prescale select divides counter input by 1, 2, 4 or 8
// [R17] sync bit: 0 synchronise external input, 1 unsynchronised; ignored internally (here both settings count the synchronised edge)
// [R18] compare source select set makes this counter the compare time base
// [R19] on bit set lets counter run; clear stops and holds value
// [R20] reset clears control, prescaler and buffer: stopped, internal, 8-bit access
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "tmc_regs.svh"

module tmc_top
    import tmc_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // clock pins and oscillator
    input  wire logic        shared_external_clock_in,
    input  wire logic        low_power_osc_clk,
    input  wire logic        low_power_osc_enable,
    // oscillator pins
    input  wire logic        oscillator_pin_one_in,
    input  wire logic        oscillator_pin_two_in,
    input  wire logic [1:0]  port_direction,
    output logic             oscillator_pin_one_read,
    output logic             oscillator_pin_two_read,
    output logic [1:0]       port_direction_used,
    // compare module
    input  wire logic        special_event_trigger,
    output logic [15:0]      count_value,
    output logic             compare_source_select,
    // interrupt request
    output logic             overflow_irq,
    output logic             overflow_irq_priority
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    tmc_byte_t   ctrl_ff,   nxt_ctrl;
    tmc_byte_t   lo_ff,     nxt_lo;
    tmc_byte_t   hi_ff,     nxt_hi;
    tmc_byte_t   hibuf_ff,  nxt_hibuf;
    logic        flag_ff,   nxt_flag;
    logic        ien_ff,    nxt_ien;
    logic        ipr_ff,    nxt_ipr;
    logic [1:0]  qdiv_ff,   nxt_qdiv;
    logic [31:0] prdata_ff, nxt_prdata;
    logic        pready_ff, nxt_pready;
    logic        perr_ff,   nxt_perr;
    logic        irq_ff,    nxt_irq;
    logic [15:0] cval_ff,   nxt_cval;
    logic [1:0]  pin_meta_ff;
    logic [1:0]  pin_sync_ff;
    logic [1:0]  pin_rd_ff, nxt_pin_rd;
    logic [1:0]  dir_ff,    nxt_dir;

    // ----------------------------------------------------------------
    // decoded terms
    // ----------------------------------------------------------------
    logic        acc_cap;
    logic        acc_done;
    logic        wr_lo;
    logic        wr_hi;
    logic        rd_lo;
    logic        wide;
    logic        mapped;
    tmc_mode_e   mode;
    logic        ext_rise;
    logic        int_tick;
    logic        pre_in;
    logic        pre_out;
    logic        trig_ok;
    logic        bump;
    logic        ovf;
    logic        cnt_write;
    logic [15:0] cnt_inc;
    tmc_byte_t   rd_byte;

    // the pin mux sits ahead of the synchroniser; switching source
    // mid-run may add or lose one count
    tmc_ext_edge u_edge (
        .sys_clk    (sys_clk),
        .nrst       (nrst),
        .clk_pin    (low_power_osc_enable ? low_power_osc_clk
                                          : shared_external_clock_in),
        .rise_pulse (ext_rise)
    );

    tmc_prescaler #(
        .SEL_W (2)
    ) u_pre (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .clear     (wr_lo), // R8
        .ratio_sel (ctrl_ff[`TMC_CTRL_PS_HI:`TMC_CTRL_PS_LO]),
        .tick_in   (pre_in),
        .tick_out  (pre_out)
    );

    // ----------------------------------------------------------------
    // bus decode and clock selection
    // ----------------------------------------------------------------
    always_comb
    begin
        acc_cap  = psel & penable & ~pready_ff;
        acc_done = psel & penable & pready_ff;
        wide     = ctrl_ff[`TMC_CTRL_WIDE];
        wr_lo    = acc_done & pwrite & (paddr == `TMC_OFF_CNT_LOW);
        wr_hi    = acc_done & pwrite & (paddr == `TMC_OFF_CNT_HIGH);
        rd_lo    = acc_cap & ~pwrite & (paddr == `TMC_OFF_CNT_LOW);
        // low writes and direct high writes are counter writes
        cnt_write = wr_lo | (wr_hi & ~wide);
        if (!ctrl_ff[`TMC_CTRL_CLK_SRC])
            mode = TMC_MODE_TIMER; // R1
        else if (!ctrl_ff[`TMC_CTRL_NOSYNC])
            mode = TMC_MODE_SYNC; // R17
        else
            mode = TMC_MODE_ASYNC; // R17
        int_tick = (qdiv_ff == `TMC_INSTR_DIV); // R2
        unique case (mode)
            TMC_MODE_TIMER: pre_in = int_tick; // R2
            TMC_MODE_SYNC:  pre_in = ext_rise; // R3
            TMC_MODE_ASYNC: pre_in = ext_rise; // R3
        endcase
        pre_in  = pre_in & ctrl_ff[`TMC_CTRL_ON]; // R19
        bump    = pre_out; // R16
        cnt_inc = {hi_ff, lo_ff} + 16'h0001;
        ovf     = bump & ({hi_ff, lo_ff} == 16'hFFFF); // R10
        // asynchronous mode cannot promise the reset, so it is dropped
        trig_ok = special_event_trigger & ctrl_ff[`TMC_CTRL_CMP_SRC]
                  & (mode != TMC_MODE_ASYNC); // R13 R14
    end

    // ----------------------------------------------------------------
    // counter, buffer and control
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_ctrl  = ctrl_ff;
        nxt_lo    = lo_ff;
        nxt_hi    = hi_ff;
        nxt_hibuf = hibuf_ff;
        nxt_qdiv  = qdiv_ff + 2'h1;
        if (cnt_write)
        begin
            if (wr_lo)
            begin
                nxt_lo = pwdata[7:0];
                if (wide)
                    nxt_hi = hibuf_ff; // R6
            end
            else
                nxt_hi = pwdata[7:0];
        end
        else if (trig_ok)
        begin
            nxt_lo = `TMC_BYTE_RST; // R13
            nxt_hi = `TMC_BYTE_RST; // R15
        end
        else if (bump)
        begin
            nxt_lo = cnt_inc[7:0]; // R10
            nxt_hi = cnt_inc[15:8];
        end
        if (wr_hi & wide)
            nxt_hibuf = pwdata[7:0]; // R6 R7
        if (rd_lo & wide)
            nxt_hibuf = hi_ff; // R5
        if (acc_done & pwrite & (paddr == `TMC_OFF_CTRL))
            nxt_ctrl = pwdata[7:0] & `TMC_CTRL_MASK; // R1
    end

    // ----------------------------------------------------------------
    // interrupt bits and side outputs
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_flag = flag_ff;
        nxt_ien  = ien_ff;
        nxt_ipr  = ipr_ff;
        if (acc_done & pwrite & (paddr == `TMC_OFF_IRQ_FLAG))
            nxt_flag = pwdata[`TMC_IRQ_BIT];
        if (acc_done & pwrite & (paddr == `TMC_OFF_IRQ_EN))
            nxt_ien = pwdata[`TMC_IRQ_BIT];
        if (acc_done & pwrite & (paddr == `TMC_OFF_IRQ_PRIO))
            nxt_ipr = pwdata[`TMC_IRQ_BIT];
        // set beats a clear in the same cycle
        if (ovf & ~cnt_write & ~trig_ok)
            nxt_flag = 1'b1; // R11
        nxt_irq  = nxt_flag & nxt_ien; // R12
        nxt_cval = {nxt_hi, nxt_lo};
        if (low_power_osc_enable)
        begin
            nxt_pin_rd = 2'h0; // R4
            nxt_dir    = 2'h3; // R4
        end
        else
        begin
            nxt_pin_rd = pin_sync_ff;
            nxt_dir    = port_direction;
        end
    end

    // ----------------------------------------------------------------
    // apb answer: one wait state, read data taken at the first access edge, write data at the second
    // ----------------------------------------------------------------
    always_comb
    begin
        mapped  = 1'b1;
        rd_byte = 8'h00;
        case (paddr)
            `TMC_OFF_CNT_LOW:  rd_byte = lo_ff;
            `TMC_OFF_CNT_HIGH: rd_byte = wide ? hibuf_ff : hi_ff; // R7
            `TMC_OFF_CTRL:     rd_byte = ctrl_ff;
            `TMC_OFF_IRQ_FLAG: rd_byte = {6'h00, flag_ff, 1'b0};
            `TMC_OFF_IRQ_EN:   rd_byte = {6'h00, ien_ff, 1'b0};
            `TMC_OFF_IRQ_PRIO: rd_byte = {6'h00, ipr_ff, 1'b0};
            default:           mapped  = 1'b0;
        endcase
        nxt_pready = acc_cap;
        nxt_prdata = prdata_ff;
        nxt_perr   = 1'b0;
        if (acc_cap)
        begin
            nxt_prdata = pwrite ? 32'h0000_0000 : {24'h000000, rd_byte};
            nxt_perr   = ~mapped;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_ff     <= `TMC_CTRL_RST; // R20
            lo_ff       <= `TMC_BYTE_RST;
            hi_ff       <= `TMC_BYTE_RST;
            hibuf_ff    <= `TMC_BYTE_RST; // R20
            flag_ff     <= 1'b0;
            ien_ff      <= 1'b0;
            ipr_ff      <= 1'b0;
            qdiv_ff     <= 2'h0;
            prdata_ff   <= 32'h0000_0000;
            pready_ff   <= 1'b0;
            perr_ff     <= 1'b0;
            irq_ff      <= 1'b0;
            cval_ff     <= 16'h0000;
            pin_meta_ff <= 2'h0;
            pin_sync_ff <= 2'h0;
            pin_rd_ff   <= 2'h0;
            dir_ff      <= 2'h3;
        end
        else
        begin
            ctrl_ff     <= nxt_ctrl;
            lo_ff       <= nxt_lo;
            hi_ff       <= nxt_hi;
            hibuf_ff    <= nxt_hibuf;
            flag_ff     <= nxt_flag;
            ien_ff      <= nxt_ien;
            ipr_ff      <= nxt_ipr;
            qdiv_ff     <= nxt_qdiv;
            prdata_ff   <= nxt_prdata;
            pready_ff   <= nxt_pready;
            perr_ff     <= nxt_perr;
            irq_ff      <= nxt_irq;
            cval_ff     <= nxt_cval;
            pin_meta_ff <= {oscillator_pin_two_in, oscillator_pin_one_in};
            pin_sync_ff <= pin_meta_ff;
            pin_rd_ff   <= nxt_pin_rd;
            dir_ff      <= nxt_dir;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_comb
    begin
        prdata                  = prdata_ff;
        pready                  = pready_ff;
        pslverr                 = perr_ff;
        count_value             = cval_ff;
        compare_source_select   = ctrl_ff[`TMC_CTRL_CMP_SRC]; // R18
        overflow_irq            = irq_ff;
        overflow_irq_priority   = ipr_ff;
        oscillator_pin_one_read = pin_rd_ff[0];
        oscillator_pin_two_read = pin_rd_ff[1];
        port_direction_used     = dir_ff;
    end

endmodule
`default_nettype wire

// ### tb/tmc_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "tmc_regs.svh"

module tmc_top_assertions
    import tmc_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // apb
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // pins, counter, request
    input  wire logic        low_power_osc_enable,
    input  wire logic        oscillator_pin_one_read,
    input  wire logic        oscillator_pin_two_read,
    input  wire logic [1:0]  port_direction_used,
    input  wire logic        special_event_trigger,
    input  wire logic [15:0] count_value,
    input  wire logic        compare_source_select,
    input  wire logic        overflow_irq
);
    logic       wr_done;
    logic       wr_low;
    logic       wr_cnt;
    logic       wr_irq;
    logic [7:0] nxt_ctrl;
    logic [7:0] ctrl_ff;

    // ----------------------------------------------------------------
    // control shadow: modes are not visible at the ports
    // ----------------------------------------------------------------
    always_comb
    begin
        wr_done  = psel && penable && pready && pwrite;
        wr_low   = wr_done && paddr == `TMC_OFF_CNT_LOW;
        wr_cnt   = wr_low || (wr_done && paddr == `TMC_OFF_CNT_HIGH);
        wr_irq   = wr_done && (paddr == `TMC_OFF_IRQ_FLAG
                   || paddr == `TMC_OFF_IRQ_EN);
        nxt_ctrl = ctrl_ff;
        if (wr_done && paddr == `TMC_OFF_CTRL)
            nxt_ctrl = pwdata[7:0] & `TMC_CTRL_MASK;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            ctrl_ff <= `TMC_CTRL_RST;
        else
            ctrl_ff <= nxt_ctrl;
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_apb_answer: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_osc_pins_zero: assert property (low_power_osc_enable |=>
        !oscillator_pin_one_read && !oscillator_pin_two_read
        && port_direction_used == 2'b11)
        else $error("oscillator pins not masked");
    a_count_step: assert property ($changed(count_value)
        && !$past(wr_cnt) && !$past(special_event_trigger)
        |-> count_value == $past(count_value) + 16'h0001)
        else $error("counter did not step by one");
    a_tick_period: assert property ($changed(count_value)
        && ctrl_ff == 8'h01 && $past(ctrl_ff) == 8'h01 && !$past(wr_cnt)
        && !$past(special_event_trigger) |=> $stable(count_value) [*3])
        else $error("internal tick faster than four clocks");
    a_stop_holds: assert property (!ctrl_ff[0] && !$past(ctrl_ff[0])
        && !wr_cnt && !special_event_trigger |=> $stable(count_value))
        else $error("stopped counter moved");
    a_trig_zeroes: assert property (special_event_trigger
        && compare_source_select && !(ctrl_ff[1] && ctrl_ff[2]) && !wr_cnt
        |=> count_value == 16'h0000)
        else $error("trigger did not clear counter");
    a_write_wins: assert property (wr_low
        |=> count_value[7:0] == $past(pwdata[7:0]))
        else $error("low byte write lost");
    a_irq_cause: assert property ($rose(overflow_irq)
        |-> $past(count_value) == 16'hFFFF || $past(count_value, 2)
        == 16'hFFFF || $past(wr_irq) || $past(wr_irq, 2))
        else $error("request rose without cause");
    a_irq_sticky: assert property ($fell(overflow_irq)
        |-> $past(wr_irq) || $past(wr_irq, 2))
        else $error("request fell without software");

    c_trig: cover property (special_event_trigger && compare_source_select);
    c_wrap: cover property ($past(count_value) == 16'hFFFF
        && count_value == 16'h0000);
    c_irq: cover property ($rose(overflow_irq));
endmodule

bind tmc_top tmc_top_assertions tmc_top_assertions_i (
    .sys_clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
    .pslverr, .low_power_osc_enable, .oscillator_pin_one_read,
    .oscillator_pin_two_read, .port_direction_used, .special_event_trigger,
    .count_value, .compare_source_select, .overflow_irq
);

`default_nettype wire

// ### tb/tb_tmc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "tmc_regs.svh"

module tb_tmc_top;
    import tmc_pkg::*;

    logic        sys_clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        ext_clk, osc_clk, osc_en, pin1, pin2, trig, trig_wr;
    logic [1:0]  pdir, pdir_used;
    logic        pin1_rd, pin2_rd, cmp_src, irq, irq_prio, err;
    logic [15:0] cnt, v;
    int          n_fail, check_count, c;

    tmc_top tmc_top_i (
        .sys_clk(sys_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .shared_external_clock_in(ext_clk), .low_power_osc_clk(osc_clk),
        .low_power_osc_enable(osc_en), .oscillator_pin_one_in(pin1),
        .oscillator_pin_two_in(pin2), .port_direction(pdir),
        .oscillator_pin_one_read(pin1_rd), .oscillator_pin_two_read(pin2_rd),
        .port_direction_used(pdir_used), .special_event_trigger(trig),
        .count_value(cnt), .compare_source_select(cmp_src),
        .overflow_irq(irq), .overflow_irq_priority(irq_prio)
    );

    always #25 sys_clk = ~sys_clk;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic complete_run;
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    // one transfer; idle edge first so no signal is set twice a step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        trig <= trig_wr;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            n_fail++;
            complete_run();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0; trig <= 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(q, {24'h000000, e});
    endtask

    task automatic wchg(output int n);
        logic [15:0] p;
        p = cnt;
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end
        while (cnt === p && n < 300);
        if (n >= 300)
        begin
            n_fail++;
            complete_run();
        end
    endtask

    task automatic pulse(input logic use_osc, input int k);
        repeat (k)
        begin
            @(posedge sys_clk);
            if (use_osc) osc_clk <= 1'b1; else ext_clk <= 1'b1;
            repeat (4) @(posedge sys_clk);
            if (use_osc) osc_clk <= 1'b0; else ext_clk <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
    endtask

    task automatic fire;
        @(posedge sys_clk);
        trig <= 1'b1;
        @(posedge sys_clk);
        trig <= 1'b0;
        @(negedge sys_clk);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        for (int a = 0; a < 24; a += 4) rdc(8'(a), 8'h00);
        apb(1'b0, 8'h20, 32'h0);
        chk({q[30:0], err}, 32'h1);
        wr(`TMC_OFF_CTRL, 8'hFF);
        rdc(`TMC_OFF_CTRL, 8'hBF);
        chk(cmp_src, 1'b1);
        wr(`TMC_OFF_CTRL, 8'h00);
    endtask

    task automatic t_wide;
        wr(`TMC_OFF_CNT_HIGH, 8'h12);
        wr(`TMC_OFF_CNT_LOW, 8'h34);
        rdc(`TMC_OFF_CNT_HIGH, 8'h12);
        wr(`TMC_OFF_CTRL, 8'h80);
        wr(`TMC_OFF_CNT_HIGH, 8'hAB);
        chk(cnt, 16'h1234);
        wr(`TMC_OFF_CNT_LOW, 8'hCD);
        chk(cnt, 16'hABCD);
        wr(`TMC_OFF_CNT_HIGH, 8'h55);
        rdc(`TMC_OFF_CNT_HIGH, 8'h55);
        rdc(`TMC_OFF_CNT_LOW, 8'hCD);
        rdc(`TMC_OFF_CNT_HIGH, 8'hAB);
        wr(`TMC_OFF_CTRL, 8'h00);
    endtask

    task automatic t_timer;
        for (int ps = 0; ps < 4; ps++)
        begin
            wr(`TMC_OFF_CTRL, 8'((ps << 4) | 1));
            wchg(c);
            wchg(c);
            chk(c, 4 << ps);
        end
        repeat (16) @(posedge sys_clk);
        wr(`TMC_OFF_CNT_LOW, 8'h00);
        wchg(c);
        chk(c > 20, 1'b1);
        wr(`TMC_OFF_CTRL, 8'h00);
        repeat (4) @(posedge sys_clk);
        v = cnt;
        repeat (40) @(posedge sys_clk);
        chk(cnt, v);
    endtask

    task automatic t_ext;
        logic [7:0] cfg [3] = '{8'h03, 8'h07, 8'h03};
        for (int i = 0; i < 3; i++)
        begin
            @(posedge sys_clk);
            osc_en <= (i == 2);
            wr(`TMC_OFF_CTRL, cfg[i]);
            pulse(i == 2, 1);
            v = cnt;
            pulse(i == 2, 5);
            chk(cnt, v + 16'h0005);
            chk({pin1_rd, pin2_rd, pdir_used}, (i == 2) ? 4'h3 : 4'hD);
        end
        @(posedge sys_clk);
        osc_en <= 1'b0;
        wr(`TMC_OFF_CTRL, 8'h00);
    endtask

    task automatic t_irq;
        wr(`TMC_OFF_CNT_HIGH, 8'hFF);
        wr(`TMC_OFF_CNT_LOW, 8'hF0);
        wr(`TMC_OFF_IRQ_EN, 8'h02);
        wr(`TMC_OFF_CTRL, 8'h01);
        c = 0;
        while (cnt !== 16'h0000 && c < 400)
        begin
            @(negedge sys_clk);
            c++;
        end
        chk(c < 400, 1'b1);
        if (c >= 400) complete_run();
        wr(`TMC_OFF_CTRL, 8'h00);
        rdc(`TMC_OFF_IRQ_FLAG, 8'h02);
        chk(irq, 1'b1);
        wr(`TMC_OFF_IRQ_EN, 8'h00);
        repeat (2) @(negedge sys_clk);
        chk(irq, 1'b0);
        rdc(`TMC_OFF_IRQ_FLAG, 8'h02);
        wr(`TMC_OFF_IRQ_EN, 8'h02);
        wr(`TMC_OFF_IRQ_FLAG, 8'h00);
        repeat (2) @(negedge sys_clk);
        chk(irq, 1'b0);
        wr(`TMC_OFF_IRQ_PRIO, 8'h02);
        chk(irq_prio, 1'b1);
    endtask

    task automatic t_trig;
        wr(`TMC_OFF_CNT_HIGH, 8'h05);
        wr(`TMC_OFF_CTRL, 8'h09);
        repeat (10) @(posedge sys_clk);
        fire();
        chk(cnt, 16'h0000);
        wr(`TMC_OFF_CTRL, 8'h01);
        repeat (10) @(posedge sys_clk);
        fire();
        chk(cnt !== 16'h0000, 1'b1);
        wr(`TMC_OFF_CTRL, 8'h09);
        wr(`TMC_OFF_CNT_HIGH, 8'h00);
        trig_wr = 1'b1;
        wr(`TMC_OFF_CNT_LOW, 8'h77);
        trig_wr = 1'b0;
        chk(cnt, 16'h0077);
        wr(`TMC_OFF_CTRL, 8'h00);
    endtask

    initial
    begin
        sys_clk = 0; nrst = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; ext_clk = 0; osc_clk = 0; osc_en = 0;
        pin1 = 1; pin2 = 1; pdir = 2'b01; trig = 0; trig_wr = 0;
        n_fail = 0; check_count = 0;
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        t_regs();
        t_wide();
        t_timer();
        t_ext();
        t_irq();
        t_trig();
        complete_run();
    end
endmodule

`default_nettype wire
